// ### core/wiper_defs.vh
`ifndef WIPER_DEFS_VH
`define WIPER_DEFS_VH

// ----------------------------------------
// timing (clock 40 MHz, period 25 ns)
// ----------------------------------------
`define CLOCK_HZ 40000000
`define DEBOUNCE_MS 8
`define AUTOSCAN_HOLD_MS 1000
`define AUTOSCAN_STEP_MS 140
`define DEBOUNCE_CYCLES (`CLOCK_HZ / 1000 * `DEBOUNCE_MS)
`define AUTOSCAN_HOLD_CYCLES (`CLOCK_HZ / 1000 * `AUTOSCAN_HOLD_MS)
`define AUTOSCAN_STEP_CYCLES (`CLOCK_HZ / 1000 * `AUTOSCAN_STEP_MS)

// ----------------------------------------
// position encoding
// ----------------------------------------
`define CODE_BITS 6
`define TAP_COUNT 64
`define CODE_MAX 6'h3f
`define CODE_RESET 6'h20

`endif

// ### core/pushbutton_wiper.v
`default_nettype none
`include "wiper_defs.vh"

module pushbutton_wiper #(
	parameter DEBOUNCE_CYCLES = `DEBOUNCE_CYCLES,
	parameter HOLD_CYCLES = `AUTOSCAN_HOLD_CYCLES,
	parameter STEP_CYCLES = `AUTOSCAN_STEP_CYCLES
) (
	// clock and reset
	input wire clock,
	input wire resetn,
	// buttons
	input wire step_up_button,
	input wire step_down_button,
	// save-enable pin
	input wire autosave_enable_indicator_in,
	output reg autosave_enable_indicator_out,
	output reg autosave_enable_indicator_oe,
	// wiper state
	output reg [5:0] wiper_position_register,
	output reg top_scale_position,
	output reg bottom_scale_position,
	output reg [63:0] tap_select,
	output reg autosave_enabled
);

	// ----------------------------------------
	// states
	// ----------------------------------------
	localparam [3:0] ST_IDLE = 4'h1;
	localparam [3:0] ST_DEB = 4'h2;
	localparam [3:0] ST_HOLD = 4'h4;
	localparam [3:0] ST_SCAN = 4'h8;

	reg [3:0] state_reg;
	reg [31:0] count_reg;
	reg dir_up_reg;
	reg sampled_reg;
	reg at_end_reg;

	// ----------------------------------------
	// button qualification
	// ----------------------------------------
	// both buttons high counts as no button
	wire up = step_up_button & ~step_down_button;
	wire down = step_down_button & ~step_up_button;
	wire any = up | down;
	wire same_dir = dir_up_reg ? up : down;

	// ----------------------------------------
	// tap decode
	// ----------------------------------------
	// one-hot decode
	function [63:0] decode_tap;
		input [5:0] code;
		begin
			decode_tap = 64'h0000000000000001 << code;
		end
	endfunction

	// ----------------------------------------
	// step strobe
	// ----------------------------------------
	// one wiper step in the chosen direction
	reg step_now;
	always @* begin
		step_now = 1'b0;
		case (state_reg)
		ST_DEB: step_now = same_dir && count_reg == DEBOUNCE_CYCLES - 1;
		ST_SCAN: step_now = same_dir && count_reg == STEP_CYCLES - 1;
		default: step_now = 1'b0;
		endcase
	end

	// ----------------------------------------
	// button sequencer
	// ----------------------------------------
	always @(posedge clock or negedge resetn) begin
		if (!resetn) begin
			state_reg <= ST_IDLE;
			count_reg <= 32'h0;
			dir_up_reg <= 1'b0;
		end else begin
			case (state_reg)
			ST_IDLE: begin
				count_reg <= 32'h0;
				if (any) begin
					dir_up_reg <= up;
					state_reg <= ST_DEB;
				end
			end
			ST_DEB: begin
				if (!same_dir) begin
					state_reg <= ST_IDLE;
					count_reg <= 32'h0;
				end else if (step_now) begin
					state_reg <= ST_HOLD;
					count_reg <= count_reg + 32'h1;
				end else begin
					count_reg <= count_reg + 32'h1;
				end
			end
			ST_HOLD: begin
				if (!same_dir) begin
					state_reg <= ST_IDLE;
					count_reg <= 32'h0;
				end else if (count_reg >= HOLD_CYCLES - 1) begin
					state_reg <= ST_SCAN;
					count_reg <= 32'h0;
				end else begin
					count_reg <= count_reg + 32'h1;
				end
			end
			ST_SCAN: begin
				if (!same_dir) begin
					state_reg <= ST_IDLE;
					count_reg <= 32'h0;
				end else if (step_now) begin
					count_reg <= 32'h0;
				end else begin
					count_reg <= count_reg + 32'h1;
				end
			end
			default: begin
				state_reg <= ST_IDLE;
				count_reg <= 32'h0;
			end
			endcase
		end
	end

	// ----------------------------------------
	// position register with end settings
	// ----------------------------------------
	always @(posedge clock or negedge resetn) begin
		if (!resetn) begin
			wiper_position_register <= `CODE_RESET;
			top_scale_position <= 1'b0;
			bottom_scale_position <= 1'b0;
			tap_select <= 64'h0000000100000000;
		end else if (step_now) begin
			// extra steps beyond the code range
			if (dir_up_reg) begin
				if (bottom_scale_position) begin
					bottom_scale_position <= 1'b0;
				end else if (wiper_position_register == `CODE_MAX) begin
					top_scale_position <= 1'b1;
				end else if (!top_scale_position) begin
					wiper_position_register <= wiper_position_register + 6'h01;
					tap_select <= decode_tap(wiper_position_register + 6'h01);
				end
				// top scale holds while up continues
			end else begin
				if (top_scale_position) begin
					top_scale_position <= 1'b0;
				end else if (wiper_position_register == 6'h00) begin
					bottom_scale_position <= 1'b1;
				end else if (!bottom_scale_position) begin
					wiper_position_register <= wiper_position_register - 6'h01;
					tap_select <= decode_tap(wiper_position_register - 6'h01);
				end
			end
		end
	end

	// ----------------------------------------
	// save-enable sampling on the first clock after reset
	// ----------------------------------------
	always @(posedge clock or negedge resetn) begin
		if (!resetn) begin
			sampled_reg <= 1'b0;
			autosave_enabled <= 1'b0;
		end else if (!sampled_reg) begin
			sampled_reg <= 1'b1;
			autosave_enabled <= ~autosave_enable_indicator_in;
		end
	end

	// ----------------------------------------
	// end-scale indicator drive
	// ----------------------------------------
	always @(posedge clock or negedge resetn) begin
		if (!resetn) begin
			at_end_reg <= 1'b0;
			autosave_enable_indicator_out <= 1'b0;
			autosave_enable_indicator_oe <= 1'b0;
		end else begin
			at_end_reg <= top_scale_position | bottom_scale_position;
			// drive high at an end while a button is active and autosave_enabled is set
			// kept through debounce until stepping off the end
			// released when no button is active
			if (autosave_enabled && any && at_end_reg &&
					(top_scale_position | bottom_scale_position)) begin
				autosave_enable_indicator_out <= 1'b1;
				autosave_enable_indicator_oe <= 1'b1;
			end else begin
				autosave_enable_indicator_out <= 1'b0;
				autosave_enable_indicator_oe <= 1'b0;
			end
		end
	end

endmodule
`default_nettype wire

// ### dv/wiper_sva.sv
`default_nettype none
module wiper_sva (
	input wire logic clock,
	resetn,
	step_up_button,
	step_down_button,
	autosave_enable_indicator_out,
	autosave_enable_indicator_oe,
	top_scale_position,
	bottom_scale_position,
	autosave_enabled,
	input wire logic [5:0] wiper_position_register,
	input wire logic [63:0] tap_select
);
	timeunit 1ns;
	timeprecision 100ps;
	wire up = step_up_button, dn = step_down_button;
	wire oe = autosave_enable_indicator_oe, am = autosave_enabled;
	wire top = top_scale_position, bot = bottom_scale_position;
	wire [5:0] code = wiper_position_register;
	default clocking @(posedge clock); endclocking
	default disable iff (!resetn);
	property p_drive; oe |-> autosave_enable_indicator_out && am; endproperty
	a_drive: assert property (p_drive) else $error("stray");
	property p_rise; (am && (top || bot) && (up ^ dn))[*4] |-> oe; endproperty
	a_rise: assert property (p_rise) else $error("no end");
	property p_free; up == dn |=> !oe; endproperty
	a_free: assert property (p_free) else $error("held");
	property p_tap; tap_select == 64'h1 << code; endproperty
	a_tap: assert property (p_tap) else $error("tap");
	property p_top; top |-> code == 6'h3f && !bot; endproperty
	a_top: assert property (p_top) else $error("top");
	property p_bot; bot |-> code == 6'h00; endproperty
	a_bot: assert property (p_bot) else $error("bottom");
	property p_step; $changed(code) |->
		code == $past(code) + 6'h1 || code == $past(code) - 6'h1; endproperty
	a_step: assert property (p_step) else $error("step");
	property p_stay; top && up && !dn |=> top; endproperty
	a_stay: assert property (p_stay) else $error("stay");
endmodule
`default_nettype wire

// ### dv/button_panel.sv
`default_nettype none
module button_panel (
	input wire logic clock,
	input wire logic autosave_enable_indicator_out,
	input wire logic autosave_enable_indicator_oe,
	output logic step_up_button,
	output logic step_down_button,
	output logic autosave_enable_indicator_in
);
	timeunit 1ns;
	timeprecision 100ps;
	logic pull = 1'b0;
	initial {step_up_button, step_down_button} = 2'b00;
	assign autosave_enable_indicator_in = autosave_enable_indicator_oe ?
		autosave_enable_indicator_out : pull;
	task press(input logic u, input int n);
		step_up_button <= u;
		step_down_button <= !u;
		repeat (n) @(posedge clock);
		step_up_button <= 1'b0;
		step_down_button <= 1'b0;
		@(posedge clock);
	endtask
endmodule
`default_nettype wire

// ### dv/pushbutton_wiper_bench.sv
`default_nettype none
module pushbutton_wiper_bench;
	timeunit 1ns;
	timeprecision 100ps;
	logic clock, resetn, step_up_button, step_down_button, autosave_enabled;
	logic autosave_enable_indicator_in, autosave_enable_indicator_out;
	logic autosave_enable_indicator_oe, top_scale_position;
	logic bottom_scale_position;
	logic [5:0] wiper_position_register;
	logic [63:0] tap_select;
	logic [7:0] last, pos, e, exp_q[$];
	int err_count, checks;
	wire [7:0] st = {top_scale_position, bottom_scale_position,
		wiper_position_register};
	pushbutton_wiper #(8, 40, 14) uut (.*);
	button_panel panel (.*);
	task check(input string nm, input logic [63:0] ex, s);
		checks++;
		if (s !== ex) begin
			err_count++;
			$display("ERROR %s exp %h got %h", nm, ex, s);
		end
	endtask
	task final_report;
		$display("errors %0d checks %0d", err_count, checks);
		if (err_count == 0 && checks > 0) $display("DONE - PASS");
		else $display("DONE - FAIL");
		$finish;
	endtask
	task go(input logic u, input int n, k);
		repeat (k) begin
			if (u ? pos[7] : pos[6]) continue;
			pos = u ? (pos[6] ? 8'h00 : pos == 8'h3f ? 8'hbf : pos + 8'h1)
				: (pos[7] ? 8'h3f : pos == 8'h00 ? 8'h40 : pos - 8'h1);
			exp_q.push_back(pos);
		end
		panel.press(u, n);
	endtask
	always @(posedge clock)
		if (!resetn) last = 8'h20;
		else if (st !== last) begin
			e = exp_q.size() ? exp_q.pop_front() : last;
			check("pos", e, st);
			check("tap", 64'h1 << e[5:0], tap_select);
			last = st;
		end
	initial begin
		clock = 0;
		forever #12.5 clock = ~clock;
	end
	initial begin
		#200us;
		err_count++;
		final_report;
	end
	initial begin
		resetn = 0;
		pos = 8'h20;
		void'($urandom(32'hf130));
		repeat (3) @(posedge clock);
		resetn <= 1;
		repeat (2) @(posedge clock);
		check("mode", 1, autosave_enabled);
		repeat (4) go(1'($urandom), 1 + $urandom % 6, 0);
		go(1, 12, 1);
		fork
			go(1, 700, 70);
			begin
				repeat (690) @(posedge clock);
				#1 check("ind", 2'b11, {autosave_enable_indicator_oe,
					autosave_enable_indicator_out});
			end
		join
		fork
			go(0, 12, 1);
			begin
				repeat (5) @(posedge clock);
				#1 check("ind", 2'b11, {autosave_enable_indicator_oe,
					autosave_enable_indicator_out});
			end
		join
		go(0, 1100, 70);
		go(1, 12, 1);
		panel.pull <= 1;
		resetn <= 0;
		pos = 8'h20;
		repeat (3) @(posedge clock);
		resetn <= 1;
		repeat (2) @(posedge clock);
		check("mode", 0, autosave_enabled);
		fork
			go(1, 700, 70);
			begin
				repeat (690) @(posedge clock);
				#1 check("ind", 0, autosave_enable_indicator_oe);
			end
		join
		check("left", 0, exp_q.size());
		final_report;
	end
endmodule
bind pushbutton_wiper wiper_sva chk (.*);
`default_nettype wire
